// ### bench/clock_request_gating_tb_top.sv
// Purpose: Self-checking bench for the clock request and gating block
// Assumes: Inputs driven 1 ns after the rising edge
// Notes: Pulse widths only judged while the overall request is steady
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; $display("mismatch %0t %h %h", $time, (a), (b)); end end
module clock_request_gating_tb_top;
    logic core_clk = 1'b0, rst_n = 1'b0, en = 1'b1, commit = 1'b0, ac = 1'b0, alt = 1'b0;
    logic frc = 1'b0, spol = 1'b0, mon_on = 1'b0, src, sreq, reg_en, stage, bias, ac_o;
    logic [3:0] rq = 4'h0, al = 4'h0, ov = 4'h0, val = 4'h0, co, seen;
    logic [7:0] drv = 8'h00, drv_o;
    int error_cnt = 0, n_tests = 0, cyc = 0, d;
    int run [4] = '{0, 0, 0, 0};
    always #2.5 core_clk = ~core_clk;
    clock_request_gating u_clock_request_gating (.core_clk(core_clk), .rst_n(rst_n),
        .enable(en), .source_clock_in(src), .request_in_1(rq[0]), .request_in_2(rq[1]),
        .request_in_3(rq[2]), .request_in_4(rq[3]), .cfg_commit(commit),
        .cfg_req_active_low(al), .cfg_req_override(ov), .cfg_req_value(val),
        .cfg_drive(drv), .cfg_emi_alt(alt), .cfg_ac_coupled(ac), .cfg_sreq_force(frc),
        .cfg_sreq_active_low(spol), .clock_out_1(co[0]), .clock_out_2(co[1]),
        .clock_out_3(co[2]), .clock_out_4(co[3]), .source_clock_request(sreq),
        .regulator_enable(reg_en), .input_stage_enable(stage), .input_bias_enable(bias),
        .drive_strength(drv_o), .ac_coupled_mode(ac_o));
    source_osc_model u_source_osc_model (.core_clk(core_clk), .rst_n(rst_n), .sreq(sreq),
        .sreq_active_low(spol), .src_clk(src));
    task results();
        if (error_cnt == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Every high pulse must last a full source half period
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            results();
        end
        seen <= seen | co;
        for (int i = 0; i < 4; i++) begin
            if (co[i] === 1'b1) run[i] <= run[i] + 1;
            else begin
                if (mon_on && run[i] != 0) `CHK(run[i], 2)
                run[i] <= 0;
            end
        end
    end
    task tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task commit_now();
        commit = 1'b1;
        tick(1);
        commit = 1'b0;
        tick(3);
    endtask
    task lvl(input logic a);
        `CHK(sreq, a ^ spol)
        `CHK(reg_en, a)
        `CHK(stage, a)
        `CHK(bias, a & ac)
    endtask
    task lanes(input logic a);
        d = 0;
        for (int k = 0; k < 8; k++) begin
            if (co[1] !== co[0]) d++;
            `CHK(co[2], ~co[0])
            if (a) `CHK(co[1], ~co[0])
            if (a) `CHK(co[3], co[0])
            tick(1);
        end
        if (!a) `CHK(d, 4)
    endtask
    task t_request();
        lvl(1'b0);
        `CHK(co, 4'h0)
        `CHK(drv_o, 8'h00)
        rq = 4'h1;
        tick(3);
        lvl(1'b1);
        mon_on = 1'b1;
        seen = 4'h0;
        tick(40);
        `CHK(seen, 4'h1)
        rq = 4'hf;
        tick(40);
        `CHK(seen, 4'hf)
        lanes(1'b0);
        mon_on = 1'b0;
        rq = 4'h0;
        tick(6);
        lvl(1'b0);
    endtask
    task t_select();
        al = 4'h2;
        commit_now();
        lvl(1'b1);
        rq = 4'h2;
        tick(3);
        lvl(1'b0);
        al = 4'h0;
        ov = 4'h8;
        val = 4'h8;
        rq = 4'h0;
        commit_now();
        lvl(1'b1);
        val = 4'h0;
        rq = 4'h8;
        commit_now();
        lvl(1'b0);
        ov = 4'h0;
        rq = 4'h0;
        frc = 1'b1;
        spol = 1'b1;
        commit_now();
        lvl(1'b1);
        frc = 1'b0;
        commit_now();
        lvl(1'b0);
        spol = 1'b0;
        drv = 8'he4;
        tick(2);
        `CHK(drv_o, 8'h00)
        ac = 1'b1;
        commit = 1'b1;
        tick(1);
        commit = 1'b0;
        tick(1);
        `CHK(drv_o, 8'he4)
        `CHK(ac_o, 1'b1)
        tick(2);
        lvl(1'b0);
        rq = 4'h1;
        tick(3);
        lvl(1'b1);
    endtask
    task t_alt_enable();
        ac = 1'b0;
        alt = 1'b1;
        rq = 4'hf;
        commit_now();
        // Let pulses that straddle the method switch die out first
        tick(8);
        mon_on = 1'b1;
        tick(32);
        lanes(1'b1);
        mon_on = 1'b0;
        en = 1'b0;
        tick(3);
        lvl(1'b0);
        tick(6);
        `CHK(co, 4'h0)
    endtask
    initial begin
        tick(5);
        rst_n = 1'b1;
        tick(2);
        t_request();
        t_select();
        t_alt_enable();
        results();
    end
endmodule
`default_nettype wire

// ### bench/source_osc_model.sv
// Purpose: Source oscillator that runs only while its request is active
// Assumes: Half period of two core_clk cycles
// Notes: Finishes a high phase before stopping, so the input never shows a runt
`timescale 1ns/100ps
`default_nettype none
module source_osc_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sreq,
    input wire logic sreq_active_low,
    output logic src_clk
);
    logic ph;
    // Stands low outside requests, like an oscillator held in standby
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_clk <= 1'b0;
            ph <= 1'b0;
        end else if ((sreq ^ sreq_active_low) || src_clk) begin
            ph <= ~ph;
            if (ph) begin
                src_clk <= ~src_clk;
            end
        end else begin
            ph <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### core/clock_gate_lane.sv
// Purpose: One gated clock output, opened and closed on a falling edge
// Assumes: tap is a registered copy of the (skewed, maybe inverted) clock
// Notes: With the tap stopped low the gate cannot change, by design
`timescale 1ns/100ps
`default_nettype none
module clock_gate_lane (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic tap,
    input wire logic want,
    output logic out
);
    logic prev_reg;
    logic prev_next;
    logic gate_reg;
    logic gate_next;
    logic out_reg;
    logic out_next;
    logic fall;

    always_comb begin
        fall = prev_reg & ~tap;
        prev_next = tap;
        // Gate moves only while the clock is low, so no partial pulse
        gate_next = fall ? want : gate_reg;
        out_next = gate_next & tap;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= 1'b0;
            gate_reg <= 1'b0;
            out_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
            gate_reg <= gate_next;
            out_reg <= out_next;
        end
    end

    assign out = out_reg;

    a_gate_on_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
        $changed(gate_reg) |-> $past(prev_reg) && !$past(tap))
        else $error("gate changed away from a falling edge");
    a_no_short_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(out_reg) |-> !$past(tap))
        else $error("output cut while high");
endmodule
`default_nettype wire

// ### core/clock_request_gating.sv
// Purpose: Request driven, glitch free gating of four clock outputs
// Assumes: All inputs synchronous to core_clk; cfg_commit marks the final ack
// Notes: Skew is in whole core_clk cycles of the sampled source clock
//
// How it works
// - One source clock feeds four outputs
// - Each output has its own request
// - Default: output runs while request high
// - Request polarity programmable per output
// - Config may override each request directly
// - Outputs start only on the falling edge of their own lane tap
// - Requests drive source request and regulator
// - Drive strength selectable in four steps
// - Default EMI: every output skewed individually
// - Alternative EMI: invert two, delay one pair
// - Input selectable DC or AC coupled
// - AC bias on only with source request
// - Shutdown fully disables input stage
// - Enable low puts everything in low power
// - Source request: any request, force, polarity
// - New config applies at final acknowledge
`timescale 1ns/100ps
`default_nettype none
module clock_request_gating (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic source_clock_in,
    input wire logic request_in_1,
    input wire logic request_in_2,
    input wire logic request_in_3,
    input wire logic request_in_4,
    input wire logic cfg_commit,
    input wire logic [3:0] cfg_req_active_low,
    input wire logic [3:0] cfg_req_override,
    input wire logic [3:0] cfg_req_value,
    input wire logic [7:0] cfg_drive,
    input wire logic cfg_emi_alt,
    input wire logic cfg_ac_coupled,
    input wire logic cfg_sreq_force,
    input wire logic cfg_sreq_active_low,
    output logic clock_out_1,
    output logic clock_out_2,
    output logic clock_out_3,
    output logic clock_out_4,
    output logic source_clock_request,
    output logic regulator_enable,
    output logic input_stage_enable,
    output logic input_bias_enable,
    output logic [7:0] drive_strength,
    output logic ac_coupled_mode
);
    // Configuration shadow
    logic [3:0] act_low_reg;
    logic [3:0] act_low_next;
    logic [3:0] override_reg;
    logic [3:0] override_next;
    logic [3:0] req_value_reg;
    logic [3:0] req_value_next;
    logic [7:0] drive_reg;
    logic [7:0] drive_next;
    logic emi_alt_reg;
    logic emi_alt_next;
    logic ac_reg;
    logic ac_next;
    logic sreq_force_reg;
    logic sreq_force_next;
    logic sreq_low_reg;
    logic sreq_low_next;

    always_comb begin
        act_low_next = act_low_reg;
        override_next = override_reg;
        req_value_next = req_value_reg;
        drive_next = drive_reg;
        emi_alt_next = emi_alt_reg;
        ac_next = ac_reg;
        sreq_force_next = sreq_force_reg;
        sreq_low_next = sreq_low_reg;
        // Loaded as a set so a half written setup is never seen
        if (cfg_commit) begin
            act_low_next = cfg_req_active_low;
            override_next = cfg_req_override;
            req_value_next = cfg_req_value;
            drive_next = cfg_drive;
            emi_alt_next = cfg_emi_alt;
            ac_next = cfg_ac_coupled;
            sreq_force_next = cfg_sreq_force;
            sreq_low_next = cfg_sreq_active_low;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            act_low_reg <= clk_gate_pkg::RST_ACT_LOW;
            override_reg <= clk_gate_pkg::RST_OVERRIDE;
            req_value_reg <= clk_gate_pkg::RST_REQ_VALUE;
            drive_reg <= clk_gate_pkg::RST_DRIVE;
            emi_alt_reg <= clk_gate_pkg::RST_EMI_ALT;
            ac_reg <= clk_gate_pkg::RST_AC_COUPLED;
            sreq_force_reg <= clk_gate_pkg::RST_SREQ_FORCE;
            sreq_low_reg <= clk_gate_pkg::RST_SREQ_LOW;
        end else begin
            act_low_reg <= act_low_next;
            override_reg <= override_next;
            req_value_reg <= req_value_next;
            drive_reg <= drive_next;
            emi_alt_reg <= emi_alt_next;
            ac_reg <= ac_next;
            sreq_force_reg <= sreq_force_next;
            sreq_low_reg <= sreq_low_next;
        end
    end

    // Request logic
    logic [3:0] req_pins;
    logic [3:0] req_eff;
    logic [3:0] want;
    logic any_req;
    logic active_reg;
    logic active_next;
    logic sreq_out_reg;
    logic sreq_out_next;
    logic bias_reg;
    logic bias_next;

    assign req_pins = {request_in_4, request_in_3, request_in_2, request_in_1};

    always_comb begin
        // Pin polarity first, then the direct override
        req_eff = override_reg & req_value_reg
            | ~override_reg & (req_pins ^ act_low_reg);
        any_req = |req_eff;
        want = req_eff & {clk_gate_pkg::NUM_OUT{enable}};
        active_next = enable & (any_req | sreq_force_reg);
        sreq_out_next = active_next ^ sreq_low_reg;
        // Committed AC bit, so the bias never outlives AC mode
        bias_next = active_next & ac_next;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_reg <= 1'b0;
            sreq_out_reg <= 1'b0;
            bias_reg <= 1'b0;
        end else begin
            active_reg <= active_next;
            sreq_out_reg <= sreq_out_next;
            bias_reg <= bias_next;
        end
    end

    // Input stage and skew line
    logic [3:0] tap_reg;
    logic [3:0] tap_next;
    logic [3:0] live_reg;
    logic [3:0] live_next;

    always_comb begin
        // Stage off forces the internal clock low even if the source toggles
        tap_next = {tap_reg[2:0], source_clock_in & active_reg};
        // Stage activity delayed in step with the taps
        live_next = {live_reg[2:0], active_reg};
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tap_reg <= clk_gate_pkg::RST_TAPS;
            live_reg <= clk_gate_pkg::RST_TAPS;
        end else begin
            tap_reg <= tap_next;
            live_reg <= live_next;
        end
    end

    // Output lanes
    logic [3:0] lane_tap;
    logic [3:0] lane_out;

    genvar i;
    generate
        for (i = 0; i < clk_gate_pkg::NUM_OUT; i++) begin : g_lane
            localparam int ALT_TAP = (i >= 2) ? clk_gate_pkg::PAIR_TAP : 0;
            // Inverted lanes gate on their own falling edge, not the source's
            // Live mask drops an inverted tap once the stage stops, else it idles high
            assign lane_tap[i] = emi_alt_reg
                ? ((tap_reg[ALT_TAP] ^ clk_gate_pkg::INV_MASK[i])
                    & live_reg[ALT_TAP])
                : tap_reg[i];
            clock_gate_lane u_lane (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .tap(lane_tap[i]),
                .want(want[i]),
                .out(lane_out[i])
            );
        end
    endgenerate

    assign clock_out_1 = lane_out[0];
    assign clock_out_2 = lane_out[1];
    assign clock_out_3 = lane_out[2];
    assign clock_out_4 = lane_out[3];
    assign source_clock_request = sreq_out_reg;
    assign regulator_enable = active_reg;
    assign input_stage_enable = active_reg;
    assign input_bias_enable = bias_reg;
    assign drive_strength = drive_reg;
    assign ac_coupled_mode = ac_reg;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    a_sreq_follows: assert property (
        ##1 source_clock_request ==
        ($past(enable && (|req_eff || sreq_force_reg)) ^ $past(sreq_low_reg)))
        else $error("source request does not follow requests");
    a_reg_enable: assert property (
        enable && |req_eff |=> regulator_enable)
        else $error("regulator not enabled by a request");
    a_low_power: assert property (
        !enable |=> !regulator_enable && !input_stage_enable && !input_bias_enable)
        else $error("block awake while enable is low");
    a_bias_gated: assert property (
        input_bias_enable |-> ac_coupled_mode && regulator_enable)
        else $error("bias on without AC mode and request");
    a_stage_off: assert property (
        !input_stage_enable |=> !tap_reg[0])
        else $error("input stage passes clock while off");
    a_cfg_hold: assert property (
        !cfg_commit |=> $stable(drive_strength) && $stable(ac_coupled_mode))
        else $error("config changed without commit");
    a_drive_load: assert property (
        cfg_commit |=> drive_strength == $past(cfg_drive))
        else $error("drive strength not loaded at commit");
    a_skew_default: assert property (
        !emi_alt_reg |-> lane_tap == tap_reg)
        else $error("default skew taps wrong");
    a_outputs_off: assert property (
        !enable ##1 !enable [*6] |-> lane_out == 4'h0)
        else $error("output running in low power");
    a_pin_polarity: assert property (
        enable && !override_reg[0] && (request_in_1 != act_low_reg[0]) |=> regulator_enable)
        else $error("active request pin did not wake the block");
    a_pins_idle: assert property (
        !sreq_force_reg && override_reg == 4'h0 && req_pins == act_low_reg
        |=> !regulator_enable)
        else $error("block awake with every request idle");
    a_low_active_pin: assert property (
        enable && !override_reg[1] && act_low_reg[1] && !request_in_2 |=> regulator_enable)
        else $error("active low request pin ignored");
    a_override_on: assert property (
        enable && override_reg[3] && req_value_reg[3] |=> regulator_enable)
        else $error("override request ignored");
    a_force_on: assert property (
        enable && sreq_force_reg |=> regulator_enable
        && source_clock_request != $past(sreq_low_reg))
        else $error("forced source request missing");
    a_sreq_idle: assert property (
        !enable |=> source_clock_request == $past(sreq_low_reg))
        else $error("source request active in low power");
    a_bias_on: assert property (
        ac_coupled_mode && regulator_enable |-> input_bias_enable)
        else $error("bias off in AC mode with a request");
    a_ac_load: assert property (
        cfg_commit |=> ac_coupled_mode == $past(cfg_ac_coupled))
        else $error("coupling mode not loaded at commit");
    a_cfg_set: assert property (
        cfg_commit |=> sreq_low_reg == $past(cfg_sreq_active_low)
        && emi_alt_reg == $past(cfg_emi_alt))
        else $error("configuration set not loaded at commit");
    a_out_from_tap: assert property (
        (lane_out & ~$past(lane_tap)) == 4'h0)
        else $error("output high without its tap");
    a_alt_invert: assert property (
        $past(emi_alt_reg) && lane_out[0] |-> !lane_out[1])
        else $error("inverted lane not opposite lane one");
endmodule
`default_nettype wire

// ### inc/clk_gate_pkg.sv
// Purpose: Shared constants for the clock request and output gating block
// Assumes: Source clock is sampled by the 200 MHz core clock
// Notes: Reset values give the default configuration
package clk_gate_pkg;
    localparam int NUM_OUT = 4;
    localparam int DRV_W = 2;
    localparam int TAP_DEPTH = 4;
    // Tap used by the delayed pair in the alternative EMI method
    localparam int PAIR_TAP = 2;
    // Lanes 2 and 4 are inverted in the alternative EMI method
    localparam logic [3:0] INV_MASK = 4'ha;
    localparam logic [3:0] RST_ACT_LOW = 4'h0;
    localparam logic [3:0] RST_OVERRIDE = 4'h0;
    localparam logic [3:0] RST_REQ_VALUE = 4'h0;
    localparam logic [7:0] RST_DRIVE = 8'h00;
    localparam logic RST_EMI_ALT = 1'b0;
    localparam logic RST_AC_COUPLED = 1'b0;
    localparam logic RST_SREQ_FORCE = 1'b0;
    localparam logic RST_SREQ_LOW = 1'b0;
    localparam logic [3:0] RST_TAPS = 4'h0;
endpackage
